// >>> design/rmsup_top.sv
// top: wishbone registers, input synchronisers, relay override/freeze and supervision hookup
//
// Contract
// - key or control input triggers relay override
// - override forces only selected relays
// - selection 5 picks relays one and three
// - pattern bits give forced relay states
// - up key function 2 triggers override
// - selection 8 freezes all relays while asserted
// - release returns relays to comparison at once
// - comparison keeps running during override
// - alarm when disabled yet still moving
// - alarm when enabled yet too slow
// - alarm when no standstill after disable
// - input function 12 enables supervision
// - polarity setting selects enable input level
// - start-up delay masks underspeed alarm only
// - alarms shown on underspeed relay
// - status shows disabled command while supervising
`default_nettype none
module rmsup_top
  import rmsup_pkg::*;
#(
  parameter int MS_TICK_CYCLES = MS_CYCLES
) (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [31:0] wb_dat_i,
  input  wire logic [3:0]  wb_sel_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  input  wire logic        key_up_i,
  input  wire logic        key_enter_i,
  input  wire logic        first_control_input_i,
  input  wire logic        second_control_input_i,
  input  wire logic [2:0]  cmp_relay_i,
  input  wire logic        spd_under_i,
  input  wire logic        spd_zero_i,
  output logic             relay_one_o,
  output logic             relay_two_o,
  output logic             relay_three_o,
  output logic             cmd_disabled_o
);
  localparam int PW = $clog2(MS_TICK_CYCLES + 1);
  localparam logic [PW-1:0] PRE_MAX = PW'(MS_TICK_CYCLES - 1);

  generate
    if (MS_TICK_CYCLES < 2) begin : g_chk
      $error("MS_TICK_CYCLES must be at least 2");
    end
  endgenerate

  // byte-lane merge for wishbone writes
  function automatic logic [31:0] wb_merge(input logic [31:0] old_v,
                                           input logic [31:0] new_v,
                                           input logic [3:0]  sel);
    logic [31:0] res;
    res = old_v;
    for (int b = 0; b < 4; b++) begin
      if (sel[b]) res[b*8 +: 8] = new_v[b*8 +: 8];
    end
    return res;
  endfunction

  logic [31:0] cmd_r;
  logic [31:0] relay_cfg_r;
  logic [31:0] startup_r;
  logic [31:0] still_r;
  logic [31:0] dat_r;
  logic        ack_r;
  logic        wr_en;
  logic [3:0]  meta_r;
  logic [3:0]  sync_r;
  logic [PW-1:0] pre_cnt_r;
  logic        tick_r;
  logic [2:0]  relay_r;
  logic [2:0]  relay_nxt;
  logic [2:0]  demand;
  logic        cmd_dis_r;
  logic        cmd_act;
  logic        freeze;
  logic        ovr;
  logic        sup_active;
  logic        enabled;
  logic        key_up_s;
  logic        key_ent_s;
  logic [1:0]  in_s;
  logic [3:0]  up_func;
  logic [3:0]  ent_func;
  logic [3:0]  in1_func;
  logic [3:0]  in2_func;
  logic [3:0]  action;
  logic [2:0]  act_pol;
  logic [1:0]  under_idx;

  rmsup_if sif ();

  ////////////////////////////////////////////////////////////////////////////
  // wishbone slave: one wait state, ack for one cycle, unmapped reads zero
  // the write lands at the ack edge, while the master still holds address and data
  assign wr_en = wb_cyc_i && wb_stb_i && wb_we_i && ack_r;

  always_ff @(posedge clk_i) begin
    if (rst_i) ack_r <= 1'b0;
    else       ack_r <= wb_cyc_i && wb_stb_i && !ack_r;
  end

  // writable configuration; status and unmapped addresses ignore writes
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cmd_r       <= CMD_RST;
      relay_cfg_r <= RELAY_RST;
      startup_r   <= STARTUP_RST;
      still_r     <= STILL_RST;
    end else if (wr_en) begin
      case (wb_adr_i)
        REG_CMD:     cmd_r       <= wb_merge(cmd_r, wb_dat_i, wb_sel_i);
        REG_RELAY:   relay_cfg_r <= wb_merge(relay_cfg_r, wb_dat_i, wb_sel_i);
        REG_STARTUP: startup_r   <= wb_merge(startup_r, wb_dat_i, wb_sel_i);
        REG_STILL:   still_r     <= wb_merge(still_r, wb_dat_i, wb_sel_i);
        default:     cmd_r       <= cmd_r;
      endcase
    end
  end

  // read data, registered alongside ack
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      dat_r <= 32'h0000_0000;
    end else begin
      case (wb_adr_i)
        REG_CMD:     dat_r <= {14'h0000, cmd_r[17:0]};
        REG_RELAY:   dat_r <= {22'h00_0000, relay_cfg_r[9:0]};
        REG_STARTUP: dat_r <= {16'h0000, startup_r[15:0]};
        REG_STILL:   dat_r <= {16'h0000, still_r[15:0]};
        REG_STATUS:  dat_r <= {23'h00_0000, enabled, ovr, freeze, sup_active,
                               sif.alarm, cmd_dis_r, relay_r};
        default:     dat_r <= 32'h0000_0000;
      endcase
    end
  end

  assign wb_ack_o = ack_r;
  assign wb_dat_o = dat_r;

  // configuration fields; unused high bits read back as zero
  assign up_func   = cmd_r[CMD_UP_LSB +: 4];
  assign ent_func  = cmd_r[CMD_ENT_LSB +: 4];
  assign in1_func  = cmd_r[CMD_IN1_LSB +: 4];
  assign in2_func  = cmd_r[CMD_IN2_LSB +: 4];
  assign action    = relay_cfg_r[RLY_ACT_LSB +: 4];
  assign act_pol   = relay_cfg_r[RLY_POL_LSB +: 3];
  assign under_idx = relay_cfg_r[RLY_UND_LSB +: 2];

  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisers; no debounce, the source keeps its level long enough
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      meta_r <= 4'h0;
      sync_r <= 4'h0;
    end else begin
      meta_r <= {second_control_input_i, first_control_input_i, key_enter_i, key_up_i};
      sync_r <= meta_r;
    end
  end

  assign key_up_s  = sync_r[0];
  assign key_ent_s = sync_r[1];
  assign in_s      = sync_r[3:2];

  // millisecond tick for the supervision timers
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pre_cnt_r <= '0;
      tick_r    <= 1'b0;
    end else if (pre_cnt_r == PRE_MAX) begin
      pre_cnt_r <= '0;
      tick_r    <= 1'b1;
    end else begin
      pre_cnt_r <= pre_cnt_r + PW'(1);
      tick_r    <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // command decode: levels only, so an edge setting would just act as a level
  assign cmd_act = (up_func == FUNC_OVERRIDE && key_up_s) ||
                   (ent_func == FUNC_OVERRIDE && key_ent_s) ||
                   (in1_func == FUNC_OVERRIDE && in_s[0]) ||
                   (in2_func == FUNC_OVERRIDE && in_s[1]);
  assign freeze  = cmd_act && action == ACT_FREEZE;
  assign ovr     = cmd_act && action != ACT_FREEZE;

  // supervision: input with function 12; polarity bit inverts the enable level
  assign sup_active = (in1_func == FUNC_SUPERV) || (in2_func == FUNC_SUPERV);
  assign enabled    = (in1_func == FUNC_SUPERV) ? (in_s[0] ^ cmd_r[CMD_POL1_BIT])
                                                : (in_s[1] ^ cmd_r[CMD_POL2_BIT]);

  assign sif.sup_active = sup_active;
  assign sif.enabled    = enabled;
  assign sif.under      = spd_under_i;
  assign sif.zero       = spd_zero_i;
  assign sif.ms_tick    = tick_r;
  assign sif.startup_ms = startup_r[15:0];
  assign sif.still_ms   = still_r[15:0];

  rmsup_supervisor u_sup (
    .clk_i (clk_i),
    .rst_i (rst_i),
    .sif   (sif.sup)
  );

  // demanded relay states: comparison, with the alarm on the underspeed relay
  always_comb begin
    demand = cmp_relay_i;
    if (sup_active && under_idx != UNDER_NONE) begin
      demand[under_idx] = sif.alarm;
    end
  end

  // relay drive: freeze holds, override forces selected bits, else follow demand
  always_comb begin
    relay_nxt = demand;
    if (freeze) begin
      relay_nxt = relay_r;
    end else if (ovr) begin
      relay_nxt = (demand & ~action[2:0]) | (act_pol & action[2:0]);
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) relay_r <= 3'h0;
    else       relay_r <= relay_nxt;
  end

  // disabled-command indicator, only meaningful while supervising
  always_ff @(posedge clk_i) begin
    if (rst_i) cmd_dis_r <= 1'b0;
    else       cmd_dis_r <= sup_active && !enabled;
  end

  assign relay_one_o    = relay_r[0];
  assign relay_two_o    = relay_r[1];
  assign relay_three_o  = relay_r[2];
  assign cmd_disabled_o = cmd_dis_r;

  ////////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  property p_freeze_hold;
    freeze |=> relay_r == $past(relay_r);
  endproperty
  a_freeze_hold: assert property (p_freeze_hold) else $error("frozen relays moved");

  property p_sel5;
    ovr && action == ACT_SEL_13 && act_pol == POL_ONLY_2 |=> !relay_r[0] && !relay_r[2];
  endproperty
  a_sel5: assert property (p_sel5) else $error("relays one/three not forced off");

  property p_pattern;
    ovr |=> (relay_r & $past(action[2:0])) == ($past(act_pol) & $past(action[2:0]));
  endproperty
  a_pattern: assert property (p_pattern) else $error("forced pattern wrong");

  property p_unsel;
    ovr |=> (relay_r & ~$past(action[2:0])) == ($past(demand) & ~$past(action[2:0]));
  endproperty
  a_unsel: assert property (p_unsel) else $error("unselected relay disturbed");

  property p_release;
    !cmd_act && $past(cmd_act) |=> relay_r == $past(demand);
  endproperty
  a_release: assert property (p_release) else $error("relays not restored");

  property p_upkey;
    up_func == FUNC_OVERRIDE && key_up_s && action != ACT_FREEZE |-> ovr;
  endproperty
  a_upkey: assert property (p_upkey) else $error("up key ignored");

  property p_input_sup;
    in1_func == FUNC_SUPERV && !cmd_r[CMD_POL1_BIT] |-> sup_active && enabled == in_s[0];
  endproperty
  a_input_sup: assert property (p_input_sup) else $error("enable polarity wrong");

  property p_status;
    sup_active && !enabled |=> cmd_disabled_o;
  endproperty
  a_status: assert property (p_status) else $error("disabled status missing");

  property p_alarm_relay;
    sup_active && !cmd_act && under_idx == 2'h1 |=> relay_two_o == $past(sif.alarm);
  endproperty
  a_alarm_relay: assert property (p_alarm_relay) else $error("alarm not on relay");

  property p_plain_under;
    !sup_active && !cmd_act |=> relay_r == $past(cmp_relay_i);
  endproperty
  a_plain_under: assert property (p_plain_under) else $error("plain relay mismatch");

  property p_ack_pulse;
    wb_ack_o |=> !wb_ack_o;
  endproperty
  a_ack_pulse: assert property (p_ack_pulse) else $error("ack longer than one cycle");

  c_freeze:   cover property (freeze ##1 freeze ##1 !cmd_act);
  c_override: cover property (ovr && action == ACT_SEL_13);
  c_alarm:    cover property (sup_active && sif.alarm && !cmd_act);
endmodule // rmsup_top
`default_nettype wire

// >>> design/rmsup_pkg.sv
// package: register map, field layout, codes and timing of the relay override supervisor
`default_nettype none
package rmsup_pkg;
  // register byte offsets
  localparam logic [7:0]  REG_CMD       = 8'h00;
  localparam logic [7:0]  REG_RELAY     = 8'h04;
  localparam logic [7:0]  REG_STARTUP   = 8'h08;
  localparam logic [7:0]  REG_STILL     = 8'h0c;
  localparam logic [7:0]  REG_STATUS    = 8'h10;
  // command register fields
  localparam int          CMD_UP_LSB    = 0;
  localparam int          CMD_ENT_LSB   = 4;
  localparam int          CMD_IN1_LSB   = 8;
  localparam int          CMD_IN2_LSB   = 12;
  localparam int          CMD_POL1_BIT  = 16;
  localparam int          CMD_POL2_BIT  = 17;
  // relay register fields
  localparam int          RLY_ACT_LSB   = 0;
  localparam int          RLY_POL_LSB   = 4;
  localparam int          RLY_UND_LSB   = 8;
  // reset values
  localparam logic [31:0] CMD_RST       = 32'h0000_0000;
  localparam logic [31:0] RELAY_RST     = 32'h0000_0300;
  localparam logic [31:0] STARTUP_RST   = 32'h0000_0000;
  localparam logic [31:0] STILL_RST     = 32'h0000_0000;
  // function and action codes
  localparam logic [3:0]  FUNC_OVERRIDE = 4'h2;
  localparam logic [3:0]  FUNC_SUPERV   = 4'hc;
  localparam logic [3:0]  ACT_FREEZE    = 4'h8;
  localparam logic [3:0]  ACT_SEL_13    = 4'h5;
  localparam logic [2:0]  POL_ONLY_2    = 3'h2;
  localparam logic [1:0]  UNDER_NONE    = 2'h3;
  // timing
  localparam int          CLK_PERIOD_NS = 10;
  localparam int          MS_NS         = 1000000;
  localparam int          MS_CYCLES     = MS_NS / CLK_PERIOD_NS;
  localparam int          STATIC_HOLD_NS  = 2000000;
  localparam int          EDGE_HOLD_NS    = 50000;
  localparam int          STATIC_HOLD_CYC = (STATIC_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int          EDGE_HOLD_CYC   = (EDGE_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // supervisor states
  typedef enum logic [1:0] {
    SUP_OFF  = 2'b00,
    SUP_RUN  = 2'b01,
    SUP_STOP = 2'b10
  } rmsup_state_t;
endpackage
`default_nettype wire

// >>> design/rmsup_if.sv
// interface: link between relay control top and the motion supervisor
`default_nettype none
interface rmsup_if;
  logic        sup_active;
  logic        enabled;
  logic        under;
  logic        zero;
  logic        ms_tick;
  logic [15:0] startup_ms;
  logic [15:0] still_ms;
  logic        alarm;
  modport ctl (output sup_active, enabled, under, zero, ms_tick, startup_ms, still_ms,
               input alarm);
  modport sup (input sup_active, enabled, under, zero, ms_tick, startup_ms, still_ms,
               output alarm);
endinterface
`default_nettype wire

// >>> design/rmsup_supervisor.sv
// motion supervisor: enable command against speed window, with start-up and standstill timers
`default_nettype none
module rmsup_supervisor
  import rmsup_pkg::*;
(
  input  wire logic clk_i,
  input  wire logic rst_i,
  rmsup_if.sup      sif
);
  rmsup_state_t state_r;
  rmsup_state_t want_st;
  logic [15:0]  su_cnt_r;
  logic [15:0]  st_cnt_r;
  logic         alarm_r;
  logic         alarm_nxt;
  logic         trans;

  // a transition also counts on entry, so timers start fresh when supervision is enabled
  assign want_st = sif.enabled ? SUP_RUN : SUP_STOP;
  assign trans   = sif.sup_active && (state_r != want_st);
  assign sif.alarm = alarm_r;

  ////////////////////////////////////////////////////////////////////////////
  // command state tracking
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_r <= SUP_OFF;
    end else begin
      case (state_r)
        SUP_OFF:  if (sif.sup_active) state_r <= want_st;
        SUP_RUN:  if (!sif.sup_active) state_r <= SUP_OFF; else state_r <= want_st;
        SUP_STOP: if (!sif.sup_active) state_r <= SUP_OFF; else state_r <= want_st;
        default:  state_r <= SUP_OFF;
      endcase
    end
  end

  // start-up delay, reloaded at each enable/disable change
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      su_cnt_r <= 16'h0000;
    end else if (trans) begin
      su_cnt_r <= sif.startup_ms;
    end else if (sif.ms_tick && su_cnt_r != 16'h0000) begin
      su_cnt_r <= su_cnt_r - 16'h0001;
    end
  end

  // standstill window, loaded only when the command falls to disabled or supervision starts disabled
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_cnt_r <= 16'h0000;
    end else if (trans && !sif.enabled) begin
      st_cnt_r <= sif.still_ms;
    end else if (sif.ms_tick && st_cnt_r != 16'h0000) begin
      st_cnt_r <= st_cnt_r - 16'h0001;
    end
  end

  // alarm decision; runs regardless of relay override so it is valid on release
  always_comb begin
    alarm_nxt = 1'b0;
    case (state_r)
      SUP_RUN:  alarm_nxt = (su_cnt_r == 16'h0000) && sif.under && !trans;
      SUP_STOP: alarm_nxt = (st_cnt_r == 16'h0000) && !sif.zero && !trans;
      default:  alarm_nxt = 1'b0;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) alarm_r <= 1'b0;
    else       alarm_r <= alarm_nxt;
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  property p_start_quiet;
    trans && sif.startup_ms != 16'h0000 |=> !alarm_r ##1 !alarm_r;
  endproperty
  a_start_quiet: assert property (p_start_quiet) else $error("alarm during start-up delay");

  property p_run_stall;
    state_r == SUP_RUN && su_cnt_r == 16'h0000 && sif.under && !trans |=> alarm_r;
  endproperty
  a_run_stall: assert property (p_run_stall) else $error("no alarm on underspeed run");

  property p_stop_move;
    state_r == SUP_STOP && st_cnt_r == 16'h0000 && !sif.zero && !trans |=> alarm_r;
  endproperty
  a_stop_move: assert property (p_stop_move) else $error("no alarm moving disabled");

  property p_off_quiet;
    !sif.sup_active |=> ##1 !alarm_r;
  endproperty
  a_off_quiet: assert property (p_off_quiet) else $error("alarm without supervision");

  c_run_alarm:  cover property (state_r == SUP_RUN && alarm_r);
  c_stop_alarm: cover property (state_r == SUP_STOP && alarm_r);
endmodule // rmsup_supervisor
`default_nettype wire

// >>> testbench/rmsup_plant.sv
// partner model: speed sensing front end and remote motion enable source
`default_nettype none
module rmsup_plant (
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  input  wire logic [2:0] dem_i,
  input  wire logic [1:0] spd_i,
  input  wire logic       cmd_i,
  output logic      [2:0] cmp_relay_o,
  output logic            spd_under_o,
  output logic            spd_zero_o,
  output logic            ctl_o
);
  timeunit 1ns;
  timeprecision 1ps;

  // speed class: 0 standstill, 1 below window, 2 inside window
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cmp_relay_o <= 3'h0;
      spd_under_o <= 1'h1;
      spd_zero_o  <= 1'h1;
    end else begin
      cmp_relay_o <= dem_i;
      spd_under_o <= (spd_i != 2'h2);
      spd_zero_o  <= (spd_i == 2'h0);
    end
  end

  // enable command is a plain level, held by the caller for many ticks
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctl_o <= 1'h0;
    end else begin
      ctl_o <= cmd_i;
    end
  end
endmodule // rmsup_plant
`default_nettype wire

// >>> testbench/rmsup_bench.sv
// testbench: bus access, relay override, freeze and motion supervision
`default_nettype none
module rmsup_bench
  import rmsup_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int TK = 10; // shortened ms tick keeps timer runs brief

  logic        clk    = 1'h0;
  logic        rst    = 1'h1;
  logic        cyc    = 1'h0;
  logic        stb    = 1'h0;
  logic        we     = 1'h0;
  logic [7:0]  adr    = 8'h00;
  logic [31:0] wdat   = 32'h0;
  logic [3:0]  sel    = 4'h0;
  logic        key_up = 1'h0;
  logic        key_ent = 1'h0;
  logic        ctl2   = 1'h0;
  logic [2:0]  dem    = 3'h0;
  logic [1:0]  spd    = 2'h0;
  logic        cmd    = 1'h0;
  wire logic [31:0] rdat;
  wire logic [2:0]  cmp;
  wire logic        ack, ctl, under, zero, r1, r2, r3, dis;
  int miscompares = 0;
  int checked     = 0;

  rmsup_top #(.MS_TICK_CYCLES(TK)) rmsup_top_inst (
    .clk_i(clk), .rst_i(rst), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_dat_i(wdat), .wb_sel_i(sel), .wb_dat_o(rdat), .wb_ack_o(ack),
    .key_up_i(key_up), .key_enter_i(key_ent), .first_control_input_i(ctl),
    .second_control_input_i(ctl2), .cmp_relay_i(cmp), .spd_under_i(under),
    .spd_zero_i(zero), .relay_one_o(r1), .relay_two_o(r2), .relay_three_o(r3),
    .cmd_disabled_o(dis));

  rmsup_plant rmsup_plant_inst (
    .clk_i(clk), .rst_i(rst), .dem_i(dem), .spd_i(spd), .cmd_i(cmd),
    .cmp_relay_o(cmp), .spd_under_o(under), .spd_zero_o(zero), .ctl_o(ctl));

  ////////////////////////////////////////////////////////////////////////
  // clock, 100 MHz
  initial begin
    forever #5 clk = ~clk;
  end

  task automatic step(input int n);
    repeat (n) @(posedge clk);
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string m);
    checked++;
    if (seen !== exp) begin
      miscompares++;
      $display("Error at %0t: %s seen %h expected %h", $time, m, seen, exp);
    end
  endtask

  task automatic flag(input logic seen, input logic exp, input string m);
    check({31'h0, seen}, {31'h0, exp}, m);
  endtask

  task automatic rly(input logic [2:0] exp, input string m);
    check({29'h0, r3, r2, r1}, {29'h0, exp}, m);
  endtask

  // classic cycle: held until ack is sampled, then one idle cycle
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d,
                    input logic [3:0] s, output logic [31:0] q);
    cyc  <= 1'h1;
    stb  <= 1'h1;
    we   <= w;
    adr  <= a;
    wdat <= d;
    sel  <= s;
    // no cycle limit here: only the watchdog ends a wait that never gets an answer
    do begin
      @(posedge clk);
    end while (ack !== 1'h1);
    q = rdat;
    cyc <= 1'h0;
    stb <= 1'h0;
    we  <= 1'h0;
    @(posedge clk);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    wb(1'h1, a, d, 4'hf, q);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e, input string m);
    logic [31:0] q;
    wb(1'h0, a, 32'h0, 4'hf, q);
    check(q, e, m);
  endtask

  task automatic end_of_test;
    if (miscompares == 0 && checked > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin : main
    logic [31:0] q;
    logic [2:0]  p;
    logic [2:0]  dv;
    step(12);
    rst <= 1'h0;
    step(1);
    rly(3'h0, "relays after reset");
    flag(dis, 1'h0, "disabled flag after reset");
    rd(REG_CMD, CMD_RST, "cmd reset value");
    rd(REG_RELAY, RELAY_RST, "relay reset value");
    rd(REG_STARTUP, STARTUP_RST, "start-up reset value");
    rd(REG_STILL, STILL_RST, "standstill reset value");
    wr(8'h20, 32'hffff_ffff);
    rd(8'h20, 32'h0, "unmapped read");
    wr(REG_STARTUP, 32'h0000_1234);
    wb(1'h1, REG_STARTUP, 32'h0000_ab00, 4'h1, q);
    rd(REG_STARTUP, 32'h0000_1200, "byte lane merge");
    // underspeed index set but no supervision input: plain comparison
    spd <= 2'h1;
    dem <= 3'h5;
    wr(REG_RELAY, 32'h0000_0100);
    step(4);
    rly(3'h5, "no supervision");
    // pattern override from the up key, forcing off then on
    wr(REG_CMD, {28'h0, FUNC_OVERRIDE});
    for (int i = 0; i < 2; i++) begin
      p  = (i == 0) ? POL_ONLY_2 : 3'h5;
      dv = (i == 0) ? 3'h7 : 3'h0;
      dem <= dv;
      wr(REG_RELAY, {22'h0, UNDER_NONE, 1'h0, p, ACT_SEL_13});
      key_up <= 1'h1;
      step(5);
      rly({p[2], dv[1], p[0]}, "pattern forced");
      dem <= ~dv;
      step(3);
      rly({p[2], ~dv[1], p[0]}, "unselected relay follows");
      key_up <= 1'h0;
      step(5);
      rly(~dv, "override released");
    end
    // freeze from the first control input
    wr(REG_CMD, {20'h0, FUNC_OVERRIDE, 8'h0});
    wr(REG_RELAY, {22'h0, UNDER_NONE, 4'h0, ACT_FREEZE});
    dem <= 3'h3;
    step(3);
    cmd <= 1'h1;
    step(6);
    dem <= 3'h4;
    step(6);
    rly(3'h3, "frozen");
    rd(REG_STATUS, 32'h0000_0043, "status while frozen");
    cmd <= 1'h0;
    step(6);
    rly(3'h4, "freeze released");
    // enter key and second input as freeze triggers, handed over without a gap
    wr(REG_CMD, {16'h0, FUNC_OVERRIDE, 4'h0, FUNC_OVERRIDE, 4'h0});
    key_ent <= 1'h1;
    step(4);
    dem <= 3'h1;
    step(6);
    rly(3'h4, "frozen by enter key");
    key_ent <= 1'h0;
    ctl2    <= 1'h1;
    step(6);
    rly(3'h4, "frozen by second input");
    ctl2 <= 1'h0;
    step(6);
    rly(3'h1, "second input released");
    // supervision, relay two underspeed, standstill longer than start-up
    dem <= 3'h0;
    spd <= 2'h0;
    wr(REG_RELAY, 32'h0000_0100);
    wr(REG_STARTUP, 32'h2);
    wr(REG_STILL, 32'h4);
    wr(REG_CMD, {20'h0, FUNC_SUPERV, 8'h0});
    step(3);
    flag(dis, 1'h1, "low input shows disabled");
    spd <= 2'h2;
    step(6 * TK);
    rly(3'h2, "moving while disabled");
    spd <= 2'h0;
    step(4);
    rly(3'h0, "stopped while disabled");
    cmd <= 1'h1;
    spd <= 2'h1;
    step(TK);
    flag(dis, 1'h0, "high input enables");
    rly(3'h0, "alarm masked during start-up");
    step(4 * TK);
    rly(3'h2, "too slow after start-up");
    spd <= 2'h2;
    step(4);
    rly(3'h0, "speed in window");
    cmd <= 1'h0;
    step(TK + 5);
    rly(3'h0, "stopping within time");
    step(6 * TK);
    rly(3'h2, "no standstill after disable");
    wr(REG_CMD, {15'h0, 1'h1, 4'h0, FUNC_SUPERV, 8'h0});
    step(3);
    flag(dis, 1'h0, "inverted: low enables");
    cmd <= 1'h1;
    step(5);
    flag(dis, 1'h1, "inverted: high disables");
    wr(REG_CMD, 32'h0);
    cmd <= 1'h0;
    dem <= 3'h2;
    spd <= 2'h1;
    step(4);
    flag(dis, 1'h0, "indicator off without supervision");
    rly(3'h2, "back to plain comparison");
    end_of_test;
  end

  // watchdog: the sequence needs about 360 cycles
  initial begin
    step(30000);
    miscompares++;
    end_of_test;
  end
endmodule // rmsup_bench
`default_nettype wire
